// *** design/ddc_pkg.sv ***
// Constants, register map and state encoding for the DDR2 pin-level controller
package ddc_pkg;

	// Software register map (byte addresses)
	localparam int          DDC_AW        = 8;
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_CMD       = 8'h04;
	localparam logic [7:0]  OFS_WDAT0     = 8'h08;
	localparam logic [7:0]  OFS_RDAT0     = 8'h18;
	localparam logic [7:0]  OFS_STAT      = 8'h28;
	localparam logic [7:0]  OFS_SPAN4     = 8'h10;

	// Field positions
	localparam int          CTRL_CKE_BIT  = 0;
	localparam int          CTRL_ODT_BIT  = 1;
	localparam int          CMD_OP_LSB    = 0;
	localparam int          CMD_BA_LSB    = 4;
	localparam int          CMD_ADDR_LSB  = 8;
	localparam int          WD_MASK_LSB   = 16;
	localparam int          ST_BUSY_BIT   = 0;
	localparam int          ST_RDV_BIT    = 1;
	localparam int          ST_DIFF_BIT   = 2;
	localparam int          ST_TMO_BIT    = 3;
	localparam logic [1:0]  RST_CTRL      = 2'h0;

	// Pin command codes {ras_n, cas_n, we_n}
	localparam logic [2:0]  CMD_MRS       = 3'h0;
	localparam logic [2:0]  CMD_REF       = 3'h1;
	localparam logic [2:0]  CMD_PRE       = 3'h2;
	localparam logic [2:0]  CMD_ACT       = 3'h3;
	localparam logic [2:0]  CMD_WR        = 3'h4;
	localparam logic [2:0]  CMD_RD        = 3'h5;
	localparam logic [2:0]  CMD_NOP       = 3'h7;

	// Address layout
	localparam int          ADDR_W        = 13;
	localparam int          COL_W         = 9;
	localparam int          AP_BIT        = 10;
	localparam logic [1:0]  EMR1_BA       = 2'h1;
	localparam int          EMR1_DQSN_BIT = 10;

	// Link clock phases (ck high in phases 0 and 1)
	localparam logic [1:0]  PH_CMD        = 2'h2;
	localparam logic [1:0]  PH_DQS_RISE   = 2'h3;
	localparam logic [1:0]  PH_DQS_FALL   = 2'h1;
	localparam logic [1:0]  PH_LAST       = 2'h3;

	// Burst and timing
	localparam int          BURST_LEN     = 4;
	localparam logic [1:0]  BEAT_LAST     = 2'h3;
	localparam logic [2:0]  EDGES_PER_RD  = 3'h4;
	localparam int          WL_CK         = 2;
	localparam int          RD_TMO_CYC    = 64;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_ISSUE  = 5'h02,
		ST_WLAT   = 5'h04,
		ST_WBURST = 5'h08,
		ST_RWAIT  = 5'h10
	} ddc_state_e;

endpackage

// *** design/ddc_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module ddc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule // ddc_sync

// *** design/ddc_clkgen.sv ***
// Divide-by-four link clock generator with phase count
`timescale 1ns/100ps
module ddc_clkgen
	import ddc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// Link clock
	output logic      [1:0] ph,
	output logic            ck,
	output logic            ck_n
);
	logic [1:0] ph_d;

	assign ph_d = ph + 2'h1;

	// Ck is high in phases 0 and 1, so it always matches ph
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ph   <= 2'h0;
			ck   <= 1'b1;
			ck_n <= 1'b0;
		end else begin
			ph   <= ph_d;
			ck   <= ~ph_d[1];
			ck_n <= ph_d[1];
		end
	end
endmodule // ddc_clkgen

// *** design/ddc_ctrl.sv ***
// DDR2 pin-level controller: command issue, write bursts, read capture
//
// Function
// - Command is the chip select plus row, column, write strobes at one edge.
// - Masks are launched per beat on both strobe edges like write data.
// - Bank inputs pick the bank for activate, read, write, single precharge.
// - Bank inputs pick base or extended mode register on a mode set.
// - Address carries row on activate, column plus auto-precharge on access.
// - Single-bank precharge takes its bank from the bank inputs.
// - Address carries the operation code on a mode register set.
// - Device drives strobe with read data, controller with write data.
// - Read strobe edges align with data; write edges sit mid-beat.
// - Lower strobe times the low data byte.
// - Upper strobe times the high data byte.
// - Controller holds clock enable high throughout every read and write.
// - Nine low address bits give the burst start column.
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module ddc_ctrl
	import ddc_pkg::*;
#(
	parameter int WL         = WL_CK,
	parameter int RD_TIMEOUT = RD_TMO_CYC
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// Software register port
	input  wire logic [DDC_AW-1:0] reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_we,
	input  wire logic              reg_re,
	output logic      [31:0]       reg_rdata,
	// Device clock and control
	output logic                   ddr_ck,
	output logic                   ddr_ck_n,
	output logic                   ddr_cke,
	output logic                   ddr_cs_n,
	output logic                   ddr_ras_n,
	output logic                   ddr_cas_n,
	output logic                   ddr_we_n,
	output logic      [1:0]        ddr_ba,
	output logic      [ADDR_W-1:0] ddr_a,
	output logic                   ddr_odt,
	output logic      [1:0]        ddr_dm,
	// Device data bus
	output logic      [15:0]       ddr_dq_o,
	output logic                   ddr_dq_oe,
	input  wire logic [15:0]       ddr_dq_i,
	// Device strobes, lane 0 low byte, lane 1 high byte
	output logic      [1:0]        ddr_dqs_o,
	output logic                   ddr_dqs_oe,
	input  wire logic [1:0]        ddr_dqs_i,
	output logic      [1:0]        ddr_dqs_n_o,
	output logic                   ddr_dqs_n_oe,
	input  wire logic [1:0]        ddr_dqs_n_i
);
	localparam int TW = $clog2(RD_TIMEOUT + 1);

	////////////////////////////////////////////////////////////////////////////
	// Clocking and input synchronisers

	logic [1:0]  ph;
	logic [15:0] dq_s;
	logic [1:0]  dqs_s;

	ddc_clkgen u_clkgen (
		.clk    (clk),
		.resetn (resetn),
		.ph     (ph),
		.ck     (ddr_ck),
		.ck_n   (ddr_ck_n)
	);

	ddc_sync #(.W(16)) u_sync_dq (
		.clk    (clk),
		.resetn (resetn),
		.d      (ddr_dq_i),
		.q      (dq_s)
	);

	ddc_sync #(.W(2)) u_sync_dqs (
		.clk    (clk),
		.resetn (resetn),
		.d      (ddr_dqs_i),
		.q      (dqs_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// State

	ddc_state_e               state_q;
	ddc_state_e               state_d;
	logic [1:0]               ctrl_q;
	logic [2:0]               op_q;
	logic [1:0]               ba_q;
	logic [ADDR_W-1:0]        addr_q;
	logic [BURST_LEN-1:0][17:0] wd_q;
	logic [3:0]               cnt_q;
	logic [1:0]               bi_q;
	logic [TW-1:0]            tmo_cnt_q;
	logic                     tmo_q;
	logic                     rdv_q;
	logic                     diff_q;
	logic [31:0]              rdata_q;
	logic                     cke_q;
	logic                     odt_q;
	logic                     cs_n_q;
	logic [2:0]               pin_cmd_q;
	logic [1:0]               pin_ba_q;
	logic [ADDR_W-1:0]        pin_a_q;
	logic [15:0]              dq_q;
	logic [1:0]               dm_q;
	logic                     dq_oe_q;
	logic                     dqs_q;
	logic                     dqs_oe_q;

	////////////////////////////////////////////////////////////////////////////
	// Register decode

	wire        st_idle  = (state_q == ST_IDLE);
	wire [7:0]  wd_off   = reg_addr - OFS_WDAT0;
	wire [7:0]  rd_off   = reg_addr - OFS_RDAT0;
	wire        wr_ctrl  = reg_we && (reg_addr == OFS_CTRL);
	// Commands are refused while one is in flight
	wire        wr_cmd   = reg_we && (reg_addr == OFS_CMD) && st_idle;
	wire        wd_hit   = (wd_off < OFS_SPAN4) && (wd_off[1:0] == 2'h0);
	wire        rd_hit   = (rd_off < OFS_SPAN4) && (rd_off[1:0] == 2'h0);
	wire        wr_wd    = reg_we && wd_hit;
	wire [1:0]  wd_idx   = wd_off[3:2];
	wire [1:0]  rd_idx   = rd_off[3:2];
	wire        is_rd    = (op_q == CMD_RD);
	wire        is_wr    = (op_q == CMD_WR);
	// A command waits out one deselected ck after the one before it
	wire        issue    = (state_q == ST_ISSUE) && (ph == PH_CMD) && cs_n_q;
	wire        wl_done  = (state_q == ST_WLAT) && (ph == PH_CMD) && (cnt_q == 4'h1);
	wire        beat_ph  = (state_q == ST_WBURST) && !ph[0];
	wire [1:0]  bi_nx    = bi_q + 2'h1;
	wire [1:0]  lane_done;
	wire [31:0] rd_word;
	wire [31:0] stat_word;
	wire [31:0] rd_mux;

	// Column accesses put auto-precharge on A10 and the column on the low bits
	wire [ADDR_W-1:0] a_col = {2'h0, addr_q[AP_BIT], 1'b0, addr_q[COL_W-1:0]};
	// Row, precharge-all flag and mode opcodes pass through unchanged
	wire [ADDR_W-1:0] a_cmd = (is_rd || is_wr) ? a_col : addr_q;
	wire emr1_wr = issue && (op_q == CMD_MRS) && (ba_q == EMR1_BA);

	assign stat_word = {28'h000_0000, tmo_q, diff_q, rdv_q, !st_idle};
	assign rd_mux    = (reg_addr == OFS_CTRL) ? {30'h0000_0000, ctrl_q} :
	                   (reg_addr == OFS_CMD)  ? {11'h000, addr_q, 2'h0, ba_q, 1'b0, op_q} :
	                   (reg_addr == OFS_STAT) ? stat_word :
	                   wd_hit                 ? {14'h0000, wd_q[wd_idx]} :
	                   rd_hit                 ? rd_word : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////
	// Software registers

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q  <= RST_CTRL;
			op_q    <= CMD_NOP;
			ba_q    <= 2'h0;
			addr_q  <= '0;
			wd_q    <= '0;
			rdata_q <= 32'h0000_0000;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata[1:0];
			end
			if (wr_cmd) begin
				op_q   <= reg_wdata[CMD_OP_LSB +: 3];
				ba_q   <= reg_wdata[CMD_BA_LSB +: 2];
				addr_q <= reg_wdata[CMD_ADDR_LSB +: ADDR_W];
			end
			if (wr_wd) begin
				wd_q[wd_idx] <= reg_wdata[17:0];
			end
			rdata_q <= reg_re ? rd_mux : 32'h0000_0000;
		end
	end

	assign reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (wr_cmd) begin
					state_d = ST_ISSUE;
				end
			end
			ST_ISSUE: begin
				if (issue) begin
					state_d = is_wr ? ST_WLAT : (is_rd ? ST_RWAIT : ST_IDLE);
				end
			end
			ST_WLAT: begin
				if (wl_done) begin
					state_d = ST_WBURST;
				end
			end
			ST_WBURST: begin
				if (beat_ph && (bi_q == BEAT_LAST)) begin
					state_d = ST_IDLE;
				end
			end
			ST_RWAIT: begin
				if ((&lane_done) || (tmo_cnt_q == TW'(RD_TIMEOUT))) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
			cnt_q   <= 4'h0;
		end else begin
			state_q <= state_d;
			if (issue) begin
				cnt_q <= 4'(WL);
			end else if ((state_q == ST_WLAT) && (ph == PH_CMD)) begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command pins: launched one clk before ck rises, held three clks past it

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cs_n_q    <= 1'b1;
			pin_cmd_q <= CMD_NOP;
			pin_ba_q  <= 2'h0;
			pin_a_q   <= '0;
			diff_q    <= 1'b0;
			cke_q     <= 1'b0;
			odt_q     <= 1'b0;
		end else begin
			if (issue) begin
				cs_n_q    <= 1'b0;
				pin_cmd_q <= op_q;
				pin_ba_q  <= ba_q;
				pin_a_q   <= a_cmd;
			end else if (ph == PH_CMD) begin
				cs_n_q    <= 1'b1;
				pin_cmd_q <= CMD_NOP;
			end
			// Track the complementary strobe enable the device was given
			if (emr1_wr) begin
				diff_q <= ~addr_q[EMR1_DQSN_BIT];
			end
			cke_q <= ctrl_q[CTRL_CKE_BIT] || wr_cmd || !st_idle;
			odt_q <= ctrl_q[CTRL_ODT_BIT];
		end
	end

	assign ddr_cke   = cke_q;
	assign ddr_odt   = odt_q;
	assign ddr_cs_n  = cs_n_q;
	assign ddr_ras_n = pin_cmd_q[2];
	assign ddr_cas_n = pin_cmd_q[1];
	assign ddr_we_n  = pin_cmd_q[0];
	assign ddr_ba    = pin_ba_q;
	assign ddr_a     = pin_a_q;

	////////////////////////////////////////////////////////////////////////////
	// Write burst: data and mask change on even phases, strobe on odd ones

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dq_q     <= 16'h0000;
			dm_q     <= 2'h0;
			dq_oe_q  <= 1'b0;
			dqs_q    <= 1'b0;
			dqs_oe_q <= 1'b0;
			bi_q     <= 2'h0;
		end else if (wl_done) begin
			dq_oe_q  <= 1'b1;
			dqs_oe_q <= 1'b1;
			dqs_q    <= 1'b0;
			dq_q     <= wd_q[0][15:0];
			dm_q     <= wd_q[0][WD_MASK_LSB +: 2];
			bi_q     <= 2'h0;
		end else if (state_q == ST_WBURST) begin
			if (ph == PH_DQS_RISE) begin
				dqs_q <= 1'b1;
			end
			if (ph == PH_DQS_FALL) begin
				dqs_q <= 1'b0;
			end
			if (beat_ph && (bi_q == BEAT_LAST)) begin
				dq_oe_q  <= 1'b0;
				dqs_oe_q <= 1'b0;
				dm_q     <= 2'h0;
			end else if (beat_ph) begin
				bi_q <= bi_nx;
				dq_q <= wd_q[bi_nx][15:0];
				dm_q <= wd_q[bi_nx][WD_MASK_LSB +: 2];
			end
		end
	end

	assign ddr_dq_o     = dq_q;
	assign ddr_dq_oe    = dq_oe_q;
	assign ddr_dm       = dm_q;
	assign ddr_dqs_o    = {2{dqs_q}};
	assign ddr_dqs_oe   = dqs_oe_q;
	assign ddr_dqs_n_o  = {2{~dqs_q}};
	// Complement strobes only driven when the device was set differential
	assign ddr_dqs_n_oe = dqs_oe_q && diff_q;

	////////////////////////////////////////////////////////////////////////////
	// Read capture per lane; the complement strobe inputs are not needed here

	genvar ln;
	generate
		for (ln = 0; ln < 2; ln++) begin : lane_g
			logic            s3_q;
			logic            armed_q;
			logic            pend_q;
			logic [2:0]      n_q;
			logic [3:0][7:0] byte_q;
			wire             edge_s = armed_q && (dqs_s[ln] != s3_q);
			wire [2:0]       n_m1   = n_q - 3'h1;

			// Arm only after the preamble low, so an idle-high bus is no edge
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					s3_q    <= 1'b0;
					armed_q <= 1'b0;
					pend_q  <= 1'b0;
					n_q     <= 3'h0;
					byte_q  <= '0;
				end else begin
					s3_q <= dqs_s[ln];
					if (issue && is_rd) begin
						armed_q <= 1'b0;
						pend_q  <= 1'b0;
						n_q     <= 3'h0;
					end else if (state_q == ST_RWAIT) begin
						if (!armed_q && !dqs_s[ln]) begin
							armed_q <= 1'b1;
						end
						pend_q <= edge_s && (n_q < EDGES_PER_RD);
						if (edge_s && (n_q < EDGES_PER_RD)) begin
							n_q <= n_q + 3'h1;
						end
						// Data is edge aligned, so take it one cycle after the edge
						if (pend_q) begin
							byte_q[n_m1[1:0]] <= dq_s[ln*8 +: 8];
						end
					end
				end
			end

			assign lane_done[ln] = (n_q == EDGES_PER_RD) && !pend_q;
		end
	endgenerate

	assign rd_word = {16'h0000, lane_g[1].byte_q[rd_idx], lane_g[0].byte_q[rd_idx]};

	////////////////////////////////////////////////////////////////////////////
	// Read completion and timeout

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdv_q     <= 1'b0;
			tmo_q     <= 1'b0;
			tmo_cnt_q <= '0;
		end else begin
			if (wr_cmd) begin
				rdv_q     <= 1'b0;
				tmo_q     <= 1'b0;
				tmo_cnt_q <= '0;
			end else if (state_q == ST_RWAIT) begin
				tmo_cnt_q <= tmo_cnt_q + TW'(1);
				if (&lane_done) begin
					rdv_q <= 1'b1;
				end else if (tmo_cnt_q == TW'(RD_TIMEOUT)) begin
					tmo_q <= 1'b1;
				end
			end
		end
	end

endmodule // ddc_ctrl

// *** tb/ddc_ctrl_assertions.sv ***
// Pin-side protocol checks for the DDR2 controller
`timescale 1ns/100ps
module ddc_ctrl_assertions
	import ddc_pkg::*;
#(
	parameter int WL = WL_CK
) (
	// Clock and reset
	input wire logic              clk,
	input wire logic              resetn,
	// Command pins
	input wire logic              ddr_ck,
	input wire logic              ddr_ck_n,
	input wire logic              ddr_cke,
	input wire logic              ddr_cs_n,
	input wire logic              ddr_ras_n,
	input wire logic              ddr_cas_n,
	input wire logic              ddr_we_n,
	input wire logic [1:0]        ddr_ba,
	input wire logic [ADDR_W-1:0] ddr_a,
	// Write data pins
	input wire logic [1:0]        ddr_dm,
	input wire logic [15:0]       ddr_dq_o,
	input wire logic              ddr_dq_oe,
	input wire logic [1:0]        ddr_dqs_o,
	input wire logic              ddr_dqs_oe,
	input wire logic [1:0]        ddr_dqs_n_o,
	input wire logic              ddr_dqs_n_oe
);
	// Write latency in system clocks
	localparam int WDLY = 4 * WL;
	wire [2:0] cmd_w = {ddr_ras_n, ddr_cas_n, ddr_we_n};
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////////////////////
	property p_cs_len;
		$fell(ddr_cs_n) |-> (!ddr_cs_n)[*4] ##1 ddr_cs_n;
	endproperty
	a_cs_len: assert property (p_cs_len) else $error("select width wrong");
	property p_cmd_hold;
		!ddr_cs_n && !$fell(ddr_cs_n) |-> $stable({cmd_w, ddr_ba, ddr_a});
	endproperty
	a_cmd_hold: assert property (p_cmd_hold) else $error("command moved");
	property p_ck_centre;
		$fell(ddr_cs_n) |-> ##1 $rose(ddr_ck) && !ddr_ck_n;
	endproperty
	a_ck_centre: assert property (p_ck_centre) else $error("ck not mid command");
	property p_nop;
		ddr_cs_n |-> cmd_w == CMD_NOP;
	endproperty
	a_nop: assert property (p_nop) else $error("code while deselected");
	property p_cke;
		(!ddr_cs_n || ddr_dq_oe) |-> ddr_cke;
	endproperty
	a_cke: assert property (p_cke) else $error("cke low in access");
	property p_col;
		!ddr_cs_n && (cmd_w == CMD_RD || cmd_w == CMD_WR) |-> ddr_a[9] == 1'b0 && ddr_a[12:11] == 2'h0;
	endproperty
	a_col: assert property (p_col) else $error("column bits wrong");
	property p_burst;
		$rose(ddr_dq_oe) |-> (ddr_dq_oe && ddr_dqs_oe)[*8] ##1 !ddr_dq_oe;
	endproperty
	a_burst: assert property (p_burst) else $error("write burst length");
	property p_wlat;
		$fell(ddr_cs_n) && cmd_w == CMD_WR |-> ##WDLY $rose(ddr_dq_oe);
	endproperty
	a_wlat: assert property (p_wlat) else $error("write latency");
	property p_dm;
		!ddr_dq_oe |-> ddr_dm == 2'h0;
	endproperty
	a_dm: assert property (p_dm) else $error("mask outside burst");
	property p_centre;
		ddr_dqs_oe && !$stable(ddr_dqs_o) |-> $stable(ddr_dq_o) && $stable(ddr_dm);
	endproperty
	a_centre: assert property (p_centre) else $error("strobe not centred");
	property p_lanes;
		ddr_dqs_oe |-> ddr_dqs_o[0] == ddr_dqs_o[1];
	endproperty
	a_lanes: assert property (p_lanes) else $error("lane strobes differ");
	property p_diff;
		ddr_dqs_n_oe |-> ddr_dqs_oe && ddr_dqs_n_o == ~ddr_dqs_o;
	endproperty
	a_diff: assert property (p_diff) else $error("complement strobe");
endmodule // ddc_ctrl_assertions
bind ddc_ctrl ddc_ctrl_assertions #(.WL(WL)) u_chk (.clk(clk), .resetn(resetn),
	.ddr_ck(ddr_ck), .ddr_ck_n(ddr_ck_n), .ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n),
	.ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba),
	.ddr_a(ddr_a), .ddr_dm(ddr_dm), .ddr_dq_o(ddr_dq_o), .ddr_dq_oe(ddr_dq_oe),
	.ddr_dqs_o(ddr_dqs_o), .ddr_dqs_oe(ddr_dqs_oe), .ddr_dqs_n_o(ddr_dqs_n_o),
	.ddr_dqs_n_oe(ddr_dqs_n_oe));

// *** tb/ddc_dev_model.sv ***
// Behavioural DDR2 device facing the controller
`timescale 1ns/100ps
module ddc_dev_model
	import ddc_pkg::*;
(
	// Link clock and command
	input wire logic              ck,
	input wire logic              cs_n,
	input wire logic              ras_n,
	input wire logic              cas_n,
	input wire logic              we_n,
	input wire logic [1:0]        ba,
	input wire logic [ADDR_W-1:0] a,
	input wire logic              odt,
	// Write side from controller
	input wire logic [15:0]       wdq,
	input wire logic [1:0]        wdm,
	input wire logic [1:0]        wdqs,
	input wire logic              wdqs_oe,
	// Bench control: never answer reads
	input wire logic              mute,
	// Read side
	output logic      [15:0]      dq,
	output logic      [1:0]       dqs,
	output logic      [1:0]       dqs_n
);
	logic [15:0] mem [4][512];
	logic [12:0] row [4];
	logic [3:0]  open_q;
	logic [12:0] mr;
	logic [12:0] emr1;
	logic [1:0]  wba;
	logic [8:0]  wcol;
	wire  [2:0]  cmd_w = {ras_n, cas_n, we_n};
	wire         term_on = odt && (emr1[6] || emr1[2]);
	// Unused complement gives a meaningless level
	assign dqs_n = emr1[EMR1_DQSN_BIT] ? 2'b01 : ~dqs;
	initial begin
		open_q = 4'h0;
		mr = 13'h0;
		emr1 = 13'h0004;
		dq = 16'hffff;
		dqs = 2'b11;
		foreach (mem[b, c]) mem[b][c] = 16'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic rd_burst(input logic [1:0] b, input logic [8:0] c);
		@(negedge ck);
		dqs <= 2'b00;
		for (int k = 0; k < BURST_LEN; k++) begin
			if (k[0]) @(negedge ck); else @(posedge ck);
			dq <= mem[b][{c[8:2], c[1:0] + 2'(k)}];
			dqs <= {2{~k[0]}};
		end
		@(posedge ck);
		dq <= ~dq;
		dqs <= ~dqs;
	endtask
	// Commands taken at the rising true clock only
	always @(posedge ck) begin
		if (!cs_n) begin
			case (cmd_w)
			CMD_ACT: begin
				row[ba] = a;
				open_q[ba] = 1'b1;
			end
			CMD_PRE: if (a[AP_BIT]) open_q = 4'h0; else open_q[ba] = 1'b0;
			CMD_MRS: if (ba == EMR1_BA) emr1 = a; else if (ba == 2'h0) mr = a;
			CMD_WR: begin
				wba = ba;
				wcol = a[8:0];
				if (a[AP_BIT]) open_q[ba] = 1'b0;
			end
			CMD_RD: begin
				if (a[AP_BIT]) open_q[ba] = 1'b0;
				if (!mute) rd_burst(ba, a[8:0]);
			end
			default: ;
			endcase
		end
	end
	for (genvar l = 0; l < 2; l++) begin : g_lane
		int n = 0;
		always @(negedge wdqs_oe) n = 0;
		always @(wdqs[l]) begin
			if (wdqs_oe && n < BURST_LEN) begin
				if (!wdm[l]) mem[wba][{wcol[8:2], wcol[1:0] + 2'(n)}][8*l +: 8] = wdq[8*l +: 8];
				n++;
			end
		end
	end
endmodule // ddc_dev_model

// *** tb/tb_ddc_ctrl.sv ***
// Register-level testbench for the DDR2 pin controller
`timescale 1ns/100ps
`define CHK(nm, e, v) begin check_count++; if ((v) !== (e)) begin fail_count++; $display("Error %s expected %h seen %h", nm, e, v); end end
module tb_ddc_ctrl;
	import ddc_pkg::*;
	logic        clk = 1'b0, resetn = 1'b0, reg_we = 1'b0, reg_re = 1'b0, mute = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic        ddr_ck, ddr_ck_n, ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n, ddr_odt;
	logic        ddr_dq_oe, ddr_dqs_oe, ddr_dqs_n_oe;
	logic [1:0]  ddr_ba, ddr_dm, ddr_dqs_o, ddr_dqs_n_o, dev_dqs, dev_dqs_n;
	logic [12:0] ddr_a;
	logic [15:0] ddr_dq_o, dev_dq;
	int          check_count = 0, fail_count = 0;
	wire  [15:0] dq_i = ddr_dq_oe ? ddr_dq_o : dev_dq;
	wire  [1:0]  dqs_i = ddr_dqs_oe ? ddr_dqs_o : dev_dqs;
	wire  [1:0]  dqs_n_i = ddr_dqs_n_oe ? ddr_dqs_n_o : dev_dqs_n;
	logic [15:0] wv [4] = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0};
	logic [1:0]  wm [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
	logic [15:0] ex [4] = '{16'h1234, 16'h5600, 16'h00bc, 16'hdef0};
	always #5 clk = ~clk;
	ddc_ctrl uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .ddr_ck(ddr_ck),
		.ddr_ck_n(ddr_ck_n), .ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n),
		.ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba), .ddr_a(ddr_a),
		.ddr_odt(ddr_odt), .ddr_dm(ddr_dm), .ddr_dq_o(ddr_dq_o), .ddr_dq_oe(ddr_dq_oe),
		.ddr_dq_i(dq_i), .ddr_dqs_o(ddr_dqs_o), .ddr_dqs_oe(ddr_dqs_oe), .ddr_dqs_i(dqs_i),
		.ddr_dqs_n_o(ddr_dqs_n_o), .ddr_dqs_n_oe(ddr_dqs_n_oe), .ddr_dqs_n_i(dqs_n_i));
	ddc_dev_model dev (.ck(ddr_ck), .cs_n(ddr_cs_n), .ras_n(ddr_ras_n), .cas_n(ddr_cas_n),
		.we_n(ddr_we_n), .ba(ddr_ba), .a(ddr_a), .odt(ddr_odt), .wdq(ddr_dq_o), .wdm(ddr_dm),
		.wdqs(ddr_dqs_o), .wdqs_oe(ddr_dqs_oe), .mute(mute), .dq(dev_dq), .dqs(dev_dqs),
		.dqs_n(dev_dqs_n));
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= ad;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic rchk(input logic [7:0] ad, input logic [31:0] e, input string nm);
		logic [31:0] d;
		rd(ad, d);
		`CHK(nm, e, d)
	endtask
	// Bounded poll so a stuck busy ends as a mismatch
	task automatic cmd(input logic [2:0] op, input logic [1:0] b, input logic [12:0] ad);
		logic [31:0] s;
		wr(OFS_CMD, {11'h0, ad, 2'h0, b, 1'b0, op});
		s = 32'h1;
		for (int i = 0; i < 40 && s[ST_BUSY_BIT]; i++)
			rd(OFS_STAT, s);
		`CHK("busy", 1'b0, s[ST_BUSY_BIT])
	endtask
	task automatic close_out;
		$display("Checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		rchk(OFS_CTRL, 32'h0, "ctrl");
		rchk(OFS_STAT, 32'h0, "stat");
		rchk(8'h2C, 32'h0, "unmapped");
		`CHK("odt_rst", 1'b0, ddr_odt)
		wr(OFS_CTRL, 32'h3);
		wr(8'h2C, 32'hffff_ffff);
		#1;
		`CHK("odt", 1'b1, ddr_odt)
		`CHK("term", 1'b1, dev.term_on)
		cmd(CMD_MRS, 2'h0, 13'h0242);
		`CHK("mr", 13'h0242, dev.mr)
		cmd(CMD_MRS, EMR1_BA, 13'h0180);
		`CHK("emr1", 13'h0180, dev.emr1)
		`CHK("term_off", 1'b0, dev.term_on)
		rchk(OFS_STAT, 32'h4, "diff");
		cmd(CMD_REF, 2'h0, 13'h0);
		cmd(CMD_ACT, 2'h2, 13'h1abc);
		`CHK("row", 13'h1abc, dev.row[2])
		for (int k = 0; k < 4; k++)
			wr(OFS_WDAT0 + 8'(4 * k), {14'h0, wm[k], wv[k]});
		cmd(CMD_WR, 2'h2, 13'h01f4);
		cmd(CMD_RD, 2'h2, 13'h05f4);
		for (int k = 0; k < 4; k++)
			rchk(OFS_RDAT0 + 8'(4 * k), {16'h0, ex[k]}, "rdata");
		rchk(OFS_STAT, 32'h6, "rd_valid");
		`CHK("autopre", 1'b0, dev.open_q[2])
		cmd(CMD_ACT, 2'h1, 13'h0010);
		cmd(CMD_ACT, 2'h3, 13'h0020);
		cmd(CMD_PRE, 2'h1, 13'h0000);
		`CHK("pre_one", 4'h8, dev.open_q)
		cmd(CMD_PRE, 2'h0, 13'h0400);
		`CHK("pre_all", 4'h0, dev.open_q)
		mute <= 1'b1;
		cmd(CMD_RD, 2'h0, 13'h0000);
		rchk(OFS_STAT, 32'hC, "timeout");
		mute <= 1'b0;
		close_out;
	end
	initial begin
		#100us;
		fail_count++;
		close_out;
	end
endmodule // tb_ddc_ctrl
